// ==== dv/mcasp_chk.sv ====
// mcasp_chk: port assertions for the audio serial port.
// assumes: bound to mcasp_core; writes reach registers only through apb access cycles.
`timescale 1ns/100ps
`default_nettype none

module mcasp_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // pins and playback valid
    input wire logic bit_clock_out,
    input wire logic bit_clock_oe,
    input wire logic frame_oe,
    input wire logic frame_out,
    input wire logic playback_valid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic wr;
    logic bclk_q;
    logic seen;
    logic [9:0] fmt_q;
    logic [8:0] cmp_q;
    logic [4:0] clk_q;
    logic [5:0] run;
    logic [5:0] half;
    assign wr = psel && penable && pwrite;
    assign half = (clk_q[4:2] > 3'h5) ? 6'd32 : 6'd1 << clk_q[4:2];
    // shadow copies of the writable registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fmt_q <= 10'h050;
            cmp_q <= 9'h000;
            clk_q <= 5'h00;
        end else if (wr && paddr == 8'h10) begin
            fmt_q <= pwdata[9:0];
        end else if (wr && paddr == 8'h14) begin
            cmp_q <= pwdata[8:0];
        end else if (wr && paddr == 8'h18) begin
            clk_q <= pwdata[4:0];
        end
    end
    // length of each bit clock level, restarted by any register write
    always_ff @(posedge sys_clk) begin
        bclk_q <= bit_clock_out;
        if (!rst_n || wr) begin
            run <= 6'd1;
            seen <= 1'b0;
        end else if (bclk_q != bit_clock_out) begin
            run <= 6'd1;
            seen <= 1'b1;
        end else if (run != 6'd63) begin
            run <= run + 6'd1;
        end
    end

    master_oe_a: assert property (wr && paddr == 8'h18 |=> bit_clock_oe == $past(pwdata[0]))
        else $error("bit clock drive does not follow master select");
    oe_pair_a: assert property (bit_clock_oe == frame_oe)
        else $error("bit clock and frame drive differ");
    reset_slave_a: assert property ($rose(rst_n) |-> !bit_clock_oe && !frame_oe)
        else $error("clock pins driven after reset");
    half_period_a: assert property (bit_clock_oe && seen && bclk_q != bit_clock_out |-> run == half)
        else $error("bit clock half period wrong");
    fmt_read_a: assert property (psel && penable && !pwrite && paddr == 8'h10 |-> prdata == {22'h0, fmt_q})
        else $error("format register read back wrong");
    cmp_read_a: assert property (psel && penable && !pwrite && paddr == 8'h14 |-> prdata == {23'h0, cmp_q})
        else $error("companding register read back wrong");
    clk_read_a: assert property (psel && penable && !pwrite && paddr == 8'h18
        |-> prdata == {27'h0, clk_q[4:2], 1'b0, clk_q[0]})
        else $error("clock register read back wrong");
    valid_pulse_a: assert property (playback_valid |=> !playback_valid)
        else $error("playback valid longer than one cycle");
    frame_edge_a: assert property (frame_oe && !$past(wr) && $changed(frame_out) |-> $changed(bit_clock_out))
        else $error("frame moved without a bit clock edge");
endmodule : mcasp_chk

`default_nettype wire

// ==== dv/mcasp_core_bench.sv ====
// mcasp_core_bench: self-checking bench of the audio serial port.
// assumes: mcasp_host clocks the pins in slave mode; this module is the apb master.
`timescale 1ns/100ps
`default_nettype none

module mcasp_core_bench;
    logic sys_clk, rst_n, psel, penable, pwrite, err;
    logic pready, pslverr, bco, bcoe, fro, froe, cap_out, pb_valid, host_bclk, host_frame, host_pb;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, cap_smp, pb_smp, rd, m, v, w_l, w_r;
    logic [10:0] c;
    logic [10:0] cfg [8] = '{11'h008, 11'h056, 11'h0e0, 11'h220, 11'h09c, 11'h05a, 11'h468, 11'h268};
    logic [2:0] dv [3] = '{3'h2, 3'h0, 3'h7};
    wire logic bclk_pin;
    wire logic frame_pin;
    int errors, samples_checked, b;
    // resolved two-way clock pins
    assign bclk_pin = bcoe ? bco : host_bclk;
    assign frame_pin = froe ? fro : host_frame;

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    mcasp_core #(.FRAME_BITS(16)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bit_clock_in(bclk_pin), .bit_clock_out(bco), .bit_clock_oe(bcoe), .frame_in(frame_pin),
        .frame_out(fro), .frame_oe(froe), .capture_serial_out(cap_out), .playback_serial_in(host_pb),
        .capture_sample(cap_smp), .playback_sample(pb_smp), .playback_valid(pb_valid));
    mcasp_host host_u (.sys_clk(sys_clk), .host_bclk(host_bclk), .host_frame(host_frame), .host_pb(host_pb),
        .cap_pin(cap_out));

    // ----------------------------------------------------------------
    // compare, apb transfer and verdict
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    // watchdog
    initial begin
        #(25 * 40000);
        errors++;
        summarize();
    end

    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, cap_smp} = '0;
        errors = 0;
        samples_checked = 0;
        v = $urandom(32'h820e_430e);
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        check({31'h0, bcoe}, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0000_0050);
        apb(1'b0, 8'h18, 32'h0);
        check(rd, 32'h0);
        v = $urandom();
        apb(1'b1, 8'h14, v);
        apb(1'b0, 8'h14, 32'h0);
        check(rd, v & 32'h0000_01ff);
        apb(1'b1, 8'h3c, v);
        apb(1'b0, 8'h3c, 32'h0);
        check({rd[30:0], err}, 32'h1);
        // slave transfers over every format
        foreach (cfg[i]) begin
            c = cfg[i];
            b = c[10] ? 8 : (c[6:5] == 0) ? 16 : (c[6:5] == 1) ? 20 : (c[6:5] == 2 || c[4:3] == 0) ? 24 : 32;
            m = 32'hffff_ffff << (32 - b);
            apb(1'b1, 8'h10, {22'h0, c[9:0]});
            apb(1'b1, 8'h14, {26'h0, c[10], 5'h0});
            apb(1'b0, 8'h1c, 32'h0);
            check({26'h0, rd[7:2]}, b);
            cap_smp <= $urandom();
            w_l = $urandom();
            w_r = $urandom();
            repeat (2) host_u.xfer(c[4:3], b, c[7], w_l, w_r);
            repeat (10) @(posedge sys_clk);
            check(pb_smp, (c[2] ? w_r : w_l) & m);
            check(host_u.cap_l, (c[9] || !c[1]) ? cap_smp & m : 32'h0);
            check(host_u.cap_r, (c[9] || c[1]) ? cap_smp & m : 32'h0);
            check(host_u.stray, 32'h0);
        end
        // master mode with inverted bit clock and several dividers
        apb(1'b1, 8'h10, 32'h0000_0108);
        check({31'h0, bco}, 32'h1);
        foreach (dv[k]) begin
            apb(1'b1, 8'h18, {27'h0, dv[k], 2'b01});
            repeat (300) @(posedge sys_clk);
            check({31'h0, bcoe & froe}, 32'h1);
        end
        apb(1'b1, 8'h18, 32'h0);
        check({31'h0, bcoe | froe}, 32'h0);
        summarize();
    end
endmodule : mcasp_core_bench

bind mcasp_core mcasp_chk chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .bit_clock_out(bit_clock_out),
    .bit_clock_oe(bit_clock_oe), .frame_oe(frame_oe), .frame_out(frame_out), .playback_valid(playback_valid));

`default_nettype wire

// ==== dv/mcasp_host.sv ====
// mcasp_host: host serial port that clocks the codec in slave mode.
// assumes: bit clock stands low between calls; data changes while bit clock is low.
`timescale 1ns/100ps
`default_nettype none

module mcasp_host (
    // clock
    input wire logic sys_clk,
    // serial pins
    output logic host_bclk,
    output logic host_frame,
    output logic host_pb,
    input wire logic cap_pin
);
    localparam int H = 8; // half bit clock in sys_clk, above the slave minimum
    logic [31:0] cap_l;
    logic [31:0] cap_r;
    int stray;
    initial begin
        host_bclk = 1'b0;
        host_frame = 1'b0;
        host_pb = 1'b0;
    end
    // one frame of 64 rises; word start slots follow the format
    task automatic xfer(input int fmt, input int b, input int pol, input logic [31:0] wl, input logic [31:0] wr);
        int ls;
        int rs;
        logic lv;
        ls = (fmt == 1) ? 1 : (fmt == 2) ? 2 : (fmt == 0) ? 33 - b : 2 - pol;
        rs = (fmt == 3) ? ls + b : ls + 32;
        lv = (fmt != 2) ^ pol[0];
        cap_l = 32'h0;
        cap_r = 32'h0;
        stray = 0;
        for (int p = 1; p <= 64; p++) begin
            @(posedge sys_clk);
            host_bclk <= 1'b0;
            host_frame <= (fmt == 3) ? (p == 1) : ((p <= 32) ? lv : !lv);
            if (p >= ls && p < ls + b) begin
                host_pb <= wl[31 - (p - ls)];
            end else if (p >= rs && p < rs + b) begin
                host_pb <= wr[31 - (p - rs)];
            end else begin
                host_pb <= p[0]; // junk outside the words
            end
            repeat (H) @(posedge sys_clk);
            host_bclk <= 1'b1;
            if (p >= ls && p < ls + b) cap_l[31 - (p - ls)] = cap_pin;
            else if (p >= rs && p < rs + b) cap_r[31 - (p - rs)] = cap_pin;
            else if (cap_pin !== 1'b0) stray++;
            repeat (H - 1) @(posedge sys_clk);
        end
        @(posedge sys_clk);
        host_bclk <= 1'b0;
    endtask : xfer
endmodule : mcasp_host

`default_nettype wire

// ==== hw/mcasp_core.sv ====
// mcasp_core: audio serial port of a mono codec with an apb register slave.
// assumes: sys_clk is the master clock; bit clock and frame pins are two-way and
// are resolved outside; capture samples come msb-aligned from codec logic on sys_clk.
//
// Notes on behaviour
// - four pins: capture out, playback in, frame, bit clock
// - master drives clocks, slave receives them
// - every format sends msb first
// - master_select high generates clocks, low follows
// - left-justified: msb on first rise after transition
// - right-justified: lsb on last rise before transition
// - i2s: msb on second rise after transition
// - dsp: right word directly follows left word
// - dsp: polarity 1 first rise, 0 second
// - master clocks divided from master clock
// - mono_duplicate sends data in both phases
// - bit_clock_invert flips bit clock
// - sync_polarity_select flips frame outside dsp
// - word_length picks 16/20/24/32, resets 24
// - format_select picks rj/lj/i2s/dsp, resets i2s
// - playback_phase_swap picks playback phase
// - capture_phase_swap picks capture phase
// - byte_word_enable forces 8-bit words
// - right-justified caps 32-bit words at 24
// - divider codes 0..5 divide by 2..64
// - master_select resets to 0, clocks inputs
`timescale 1ns/100ps
`default_nettype none
`include "mcasp_map.svh"

module mcasp_core #(
    parameter int FRAME_BITS = `MCASP_FRAME_BITS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // bit clock pin
    input wire logic bit_clock_in,
    output logic bit_clock_out,
    output logic bit_clock_oe,
    // frame pin
    input wire logic frame_in,
    output logic frame_out,
    output logic frame_oe,
    // serial data pins
    output logic capture_serial_out,
    input wire logic playback_serial_in,
    // codec side samples
    input wire logic [31:0] capture_sample,
    output logic [31:0] playback_sample,
    output logic playback_valid
);

    // ------------
    // registers and decoded controls
    // ------------
    logic [`MCASP_FMT_WIDTH-1:0] audio_port_format_control;
    logic [`MCASP_CMP_WIDTH-1:0] companding_control;
    logic [`MCASP_CLK_WIDTH-1:0] clock_generation_control;
    logic master_select;
    logic [2:0] bit_clock_divider;
    logic mono_duplicate;
    logic bit_clock_invert;
    logic sync_polarity_select;
    logic [1:0] word_length;
    mcasp_pkg::mcasp_fmt_t format_select;
    logic playback_phase_swap;
    logic capture_phase_swap;
    logic byte_word_enable;
    logic is_dsp;
    logic [5:0] word_bits;

    assign master_select = clock_generation_control[`MCASP_BIT_MASTER];
    assign bit_clock_divider = clock_generation_control[`MCASP_POS_DIV_HI:`MCASP_POS_DIV_LO];
    assign mono_duplicate = audio_port_format_control[`MCASP_BIT_MONO_DUP];
    assign bit_clock_invert = audio_port_format_control[`MCASP_BIT_BCLK_INV];
    assign sync_polarity_select = audio_port_format_control[`MCASP_BIT_SYNC_POL];
    assign word_length = audio_port_format_control[`MCASP_POS_WL_HI:`MCASP_POS_WL_LO];
    assign format_select = mcasp_pkg::mcasp_fmt_t'(audio_port_format_control[`MCASP_POS_FMT_HI:`MCASP_POS_FMT_LO]);
    assign playback_phase_swap = audio_port_format_control[`MCASP_BIT_PB_SWAP];
    assign capture_phase_swap = audio_port_format_control[`MCASP_BIT_CAP_SWAP];
    assign byte_word_enable = companding_control[`MCASP_BIT_BYTE_WORD];
    assign is_dsp = (format_select == mcasp_pkg::MCASP_FMT_DSP);

    // effective word length in bits
    always_comb begin
        if (byte_word_enable) begin
            word_bits = `MCASP_WL_8;
        end else begin
            unique case (word_length)
                2'h0: word_bits = `MCASP_WL_16;
                2'h1: word_bits = `MCASP_WL_20;
                2'h2: word_bits = `MCASP_WL_24;
                2'h3: word_bits = (format_select == mcasp_pkg::MCASP_FMT_RJ) ? `MCASP_WL_24 : `MCASP_WL_32;
            endcase
        end
    end

    // ------------
    // apb slave
    // ------------
    logic [5:0] reg_index;
    logic mapped;
    logic apb_write;
    logic apb_setup;
    logic frame_level_logical;
    logic [31:0] status_word;

    assign reg_index = paddr[7:2];
    assign mapped = (paddr[1:0] == 2'h0) &&
                    (reg_index == `MCASP_IDX_FORMAT || reg_index == `MCASP_IDX_COMPAND ||
                     reg_index == `MCASP_IDX_CLOCK || reg_index == `MCASP_IDX_STATUS ||
                     reg_index == `MCASP_IDX_PLAYBACK);
    assign apb_write = psel && penable && pwrite && mapped;
    assign apb_setup = psel && !penable;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign status_word = {24'h00_0000, word_bits, frame_level_logical, master_select};

    // register writes in the access phase
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            audio_port_format_control <= `MCASP_FMT_RESET;
            companding_control <= `MCASP_CMP_RESET;
            clock_generation_control <= `MCASP_CLK_RESET;
        end else if (apb_write) begin
            if (reg_index == `MCASP_IDX_FORMAT) begin
                audio_port_format_control <= pwdata[`MCASP_FMT_WIDTH-1:0];
            end
            if (reg_index == `MCASP_IDX_COMPAND) begin
                companding_control <= pwdata[`MCASP_CMP_WIDTH-1:0];
            end
            if (reg_index == `MCASP_IDX_CLOCK) begin
                clock_generation_control <= pwdata[`MCASP_CLK_WIDTH-1:0] &
                                            {3'h7, 1'b0, 1'b1}; // bit 1 reserved
            end
        end
    end

    // read data captured in the setup phase, held through the access phase
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup && !pwrite) begin
            unique case (1'b1)
                (mapped && reg_index == `MCASP_IDX_FORMAT): prdata <= {22'h00_0000, audio_port_format_control};
                (mapped && reg_index == `MCASP_IDX_COMPAND): prdata <= {23'h00_0000, companding_control};
                (mapped && reg_index == `MCASP_IDX_CLOCK): prdata <= {27'h000_0000, clock_generation_control};
                (mapped && reg_index == `MCASP_IDX_STATUS): prdata <= status_word;
                (mapped && reg_index == `MCASP_IDX_PLAYBACK): prdata <= playback_sample;
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------
    // pin synchronisers
    // ------------
    logic [2:0] pins_sync;

    mcasp_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .async_in({playback_serial_in, frame_in, bit_clock_in}),
        .sync_out(pins_sync)
    );

    // ------------
    // master clock generation
    // ------------
    logic [5:0] div_count;
    logic [5:0] div_half;
    logic div_tick;
    logic bclk_gen;
    logic frame_gen;
    logic [7:0] gen_bit_count;
    logic [7:0] gen_half_bits;

    // bit clock half period in sys_clk cycles; reserved codes hold at 32
    assign div_half = (bit_clock_divider > `MCASP_DIV_MAX) ? 6'd32 : (6'd1 << bit_clock_divider);
    assign div_tick = (div_count == div_half - 6'd1);
    assign gen_half_bits = 8'(FRAME_BITS / 2);

    // bit clock divider, runs only while master
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !master_select) begin
            div_count <= 6'd0;
            bclk_gen <= 1'b0;
        end else if (div_tick) begin
            div_count <= 6'd0;
            bclk_gen <= !bclk_gen;
        end else begin
            div_count <= div_count + 6'd1;
        end
    end

    // frame generator, moves on the falling edge of the generated bit clock
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !master_select) begin
            gen_bit_count <= 8'd0;
            frame_gen <= 1'b0;
        end else if (div_tick && bclk_gen) begin
            gen_bit_count <= (gen_bit_count == 8'(FRAME_BITS - 1)) ? 8'd0 : gen_bit_count + 8'd1;
            if (is_dsp) begin
                frame_gen <= (gen_bit_count == 8'(FRAME_BITS - 1)); // one bit wide pulse
            end else if (gen_bit_count == gen_half_bits - 8'd1 || gen_bit_count == 8'(FRAME_BITS - 1)) begin
                frame_gen <= !frame_gen;
            end
        end
    end

    // pins: outputs enabled only as master
    assign bit_clock_oe = master_select;
    assign frame_oe = master_select;
    assign bit_clock_out = bclk_gen ^ bit_clock_invert;
    assign frame_out = frame_gen ^ (sync_polarity_select && !is_dsp);

    // ------------
    // edge detection of bit clock and frame
    // ------------
    logic bclk_level;
    logic bclk_prev;
    logic frame_level;
    logic frame_prev;
    logic bclk_rise;
    logic bclk_fall;
    logic frame_event;

    // logical levels: slave pins are undone of their polarity
    assign bclk_level = master_select ? bclk_gen : (pins_sync[0] ^ bit_clock_invert);
    assign frame_level = master_select ? frame_gen : (pins_sync[1] ^ (sync_polarity_select && !is_dsp));
    assign frame_level_logical = frame_level;
    assign bclk_rise = bclk_level && !bclk_prev;
    assign bclk_fall = !bclk_level && bclk_prev;
    assign frame_event = is_dsp ? (frame_level && !frame_prev) : (frame_level != frame_prev);

    // previous levels for edge detection
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bclk_prev <= 1'b0;
            frame_prev <= 1'b0;
        end else begin
            bclk_prev <= bclk_level;
            frame_prev <= frame_level;
        end
    end

    // ------------
    // position within the frame half
    // ------------
    logic [8:0] rise_count;
    logic [8:0] half_len;
    logic [8:0] next_edge;
    mcasp_pkg::mcasp_slot_t slot;

    // rising edges since the last frame transition, and length of the last half
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rise_count <= 9'd0;
            half_len <= 9'd0;
        end else if (frame_event) begin
            rise_count <= 9'd0;
            half_len <= rise_count;
        end else if (bclk_rise && rise_count != 9'h1ff) begin
            rise_count <= rise_count + 9'd1;
        end
    end

    // edge number that the next rising edge will carry
    assign next_edge = frame_event ? 9'd1 : rise_count + 9'd1;

    // map a rising edge number to a word bit and a channel phase
    function automatic mcasp_pkg::mcasp_slot_t slot_of(input logic [8:0] edge_num);
        logic signed [11:0] offset;
        logic signed [11:0] j;
        logic signed [11:0] wl;
        mcasp_pkg::mcasp_slot_t s;
        wl = $signed({6'h00, word_bits});
        s = '0;
        unique case (format_select)
            mcasp_pkg::MCASP_FMT_LJ: offset = 12'sd1;
            mcasp_pkg::MCASP_FMT_I2S: offset = 12'sd2;
            mcasp_pkg::MCASP_FMT_DSP: offset = sync_polarity_select ? 12'sd1 : 12'sd2;
            mcasp_pkg::MCASP_FMT_RJ: offset = 12'sd1 + $signed({3'h0, half_len}) - wl;
        endcase
        j = $signed({3'h0, edge_num}) - offset;
        if (is_dsp) begin
            // left word then right word with no gap between them
            s.valid = (j >= 12'sd0) && (j < (wl <<< 1));
            s.left = (j < wl);
            s.pos = s.left ? j[5:0] : 6'(j - wl);
        end else begin
            s.valid = (j >= 12'sd0) && (j < wl);
            s.left = (format_select == mcasp_pkg::MCASP_FMT_I2S) ? !frame_level : frame_level;
            s.pos = j[5:0];
        end
        return s;
    endfunction : slot_of

    always_comb slot = slot_of(next_edge); // a process sees all state the function reads

    // ------------
    // capture serialiser
    // ------------
    logic [31:0] capture_word;
    logic capture_phase_ok;

    assign capture_phase_ok = mono_duplicate || (slot.left != capture_phase_swap);

    // capture word is held stable from one frame transition to the next
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            capture_word <= 32'h0000_0000;
        end else if (frame_event) begin
            capture_word <= capture_sample;
        end
    end

    // next bit is set up on a frame transition or a falling bit clock edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            capture_serial_out <= 1'b0;
        end else if (frame_event || bclk_fall) begin
            if (slot.valid && capture_phase_ok) begin
                // msb-aligned sample, bit 31 leaves first
                capture_serial_out <= (frame_event ? capture_sample[5'(31 - slot.pos)] :
                                       capture_word[5'(31 - slot.pos)]);
            end else begin
                capture_serial_out <= 1'b0;
            end
        end
    end

    // ------------
    // playback deserialiser
    // ------------
    logic [31:0] playback_shift;
    logic playback_take;
    logic [31:0] next_shift;

    // input bit is taken on a rising edge inside the selected phase only
    assign playback_take = bclk_rise && !frame_event && slot.valid &&
                           (slot.left != playback_phase_swap);

    // new shift contents with the current bit put in place, msb first
    always_comb begin
        next_shift = (slot.pos == 6'd0) ? 32'h0000_0000 : playback_shift;
        next_shift[5'(31 - slot.pos)] = pins_sync[2];
    end

    // shift register and completed sample
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            playback_shift <= 32'h0000_0000;
            playback_sample <= 32'h0000_0000;
            playback_valid <= 1'b0;
        end else begin
            playback_valid <= 1'b0;
            if (playback_take) begin
                playback_shift <= next_shift;
                if (slot.pos == word_bits - 6'd1) begin
                    playback_sample <= next_shift;
                    playback_valid <= 1'b1;
                end
            end
        end
    end

endmodule : mcasp_core
`default_nettype wire

// ==== hw/mcasp_map.svh ====
// mcasp_map.svh: register indices, field positions, reset values and timing figures
// of the mono codec audio serial port.
// assumes: included by bare name; byte address of a register is four times its index.
`ifndef MCASP_MAP_SVH
`define MCASP_MAP_SVH

// ----------------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define MCASP_IDX_FORMAT 6'h04
`define MCASP_IDX_COMPAND 6'h05
`define MCASP_IDX_CLOCK 6'h06
`define MCASP_IDX_STATUS 6'h07
`define MCASP_IDX_PLAYBACK 6'h08

// ----------------------------------------------------------------------------
// audio_port_format_control fields
// ----------------------------------------------------------------------------
`define MCASP_FMT_WIDTH 10
`define MCASP_FMT_RESET 10'h050
`define MCASP_BIT_MONO_DUP 9
`define MCASP_BIT_BCLK_INV 8
`define MCASP_BIT_SYNC_POL 7
`define MCASP_POS_WL_HI 6
`define MCASP_POS_WL_LO 5
`define MCASP_POS_FMT_HI 4
`define MCASP_POS_FMT_LO 3
`define MCASP_BIT_PB_SWAP 2
`define MCASP_BIT_CAP_SWAP 1

// ----------------------------------------------------------------------------
// companding_control fields
// ----------------------------------------------------------------------------
`define MCASP_CMP_WIDTH 9
`define MCASP_CMP_RESET 9'h000
`define MCASP_BIT_BYTE_WORD 5

// ----------------------------------------------------------------------------
// clock generation control fields
// ----------------------------------------------------------------------------
`define MCASP_CLK_WIDTH 5
`define MCASP_CLK_RESET 5'h00
`define MCASP_POS_DIV_HI 4
`define MCASP_POS_DIV_LO 2
`define MCASP_BIT_MASTER 0

// ----------------------------------------------------------------------------
// word lengths in bits and default frame size in master mode
// ----------------------------------------------------------------------------
`define MCASP_WL_8 6'd8
`define MCASP_WL_16 6'd16
`define MCASP_WL_20 6'd20
`define MCASP_WL_24 6'd24
`define MCASP_WL_32 6'd32
`define MCASP_DIV_MAX 3'h5
`define MCASP_FRAME_BITS 64

`endif

// ==== hw/mcasp_pkg.sv ====
// mcasp_pkg: types shared by the audio serial port files.
// assumes: compiled before every module that names it.
package mcasp_pkg;

    // data format codes as held in the format field
    typedef enum logic [1:0] {
        MCASP_FMT_RJ = 2'h0,
        MCASP_FMT_LJ = 2'h1,
        MCASP_FMT_I2S = 2'h2,
        MCASP_FMT_DSP = 2'h3
    } mcasp_fmt_t;

    // where one bit-clock edge falls inside the frame
    typedef struct packed {
        logic valid;
        logic left;
        logic [5:0] pos;
    } mcasp_slot_t;

endpackage : mcasp_pkg

// ==== hw/mcasp_sync.sv ====
// mcasp_sync: two flip-flop synchroniser for a group of pin levels.
// assumes: inputs are asynchronous to clk; only the second stage is read outside.
`timescale 1ns/100ps
`default_nettype none

module mcasp_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // two stages per bit, reset low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : mcasp_sync
`default_nettype wire
